/* File: hdl/rsx_exec.sv */
// execute core for rotate-right, set-file, sleep and subtract-with-borrow
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rsx_defines.svh"
module rsx_exec (
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    // instruction and mode
    input  wire logic              instr_valid_in,
    input  wire logic [15:0]       instr_in,
    input  wire logic              ext_mode_in,
    input  wire logic [3:0]        bank_select_reg_in,
    input  wire logic [11:0]       index_base_in,
    input  wire logic              watchdog_wake_in,
    // data memory
    output logic [11:0]            mem_addr_out,
    input  wire logic [7:0]        mem_rdata_in,
    output logic                   mem_we_out,
    output logic [7:0]             mem_wdata_out,
    // core state
    output logic [7:0]             acc_out,
    output logic [4:0]             status_out,
    output logic                   timeout_status_bit_out,
    output logic                   power_down_status_bit_out,
    output logic                   watchdog_clear_out,
    output logic                   sleeping_out,
    output rsx_pkg::rsx_phase_e    phase_out,
    output logic                   busy_out
);
    import rsx_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    rsx_phase_e  phase_r, phase_nxt;
    logic        busy_r, busy_nxt;
    logic [15:0] ir_r, ir_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [7:0]  opnd_r, opnd_nxt;
    logic [7:0]  res_r, res_nxt;
    logic [4:0]  flg_r, flg_nxt;
    logic [7:0]  acc_r, acc_nxt;
    logic        to_r, to_nxt;
    logic        pwrdn_r, pwrdn_nxt;
    logic        sleep_r, sleep_nxt;
    logic        wdclr_r, wdclr_nxt;
    logic        we_r, we_nxt;
    logic [7:0]  wd_r, wd_nxt;

    logic        is_rrnc, is_setall, is_subb, is_sleep;
    logic [8:0]  diff;
    logic [4:0]  ldiff;
    logic [7:0]  rot;
    logic [4:0]  flg_new;

    rsx_addr_if ai ();
    rsx_addr_former rsx_addr_former_inst (
        .ai (ai)
    );

    assign ai.bank_sel   = ir_r[`RSX_BIT_A];
    assign ai.ext_mode   = ext_mode_in;
    assign ai.file_lit   = ir_r[7:0];
    assign ai.bank_reg   = bank_select_reg_in;
    assign ai.index_base = index_base_in;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign is_rrnc  = (ir_r[15:10] == `RSX_OP6_RRNC);
    assign is_subb  = (ir_r[15:10] == `RSX_OP6_SUBB);
    assign is_setall = (ir_r[15:9] == `RSX_OP7_SET1);
    assign is_sleep = (ir_r == `RSX_SLEEP_WORD);

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    // low carry into subtract is the inverted carry, i.e. borrow
    assign diff  = {1'b0, acc_r} - {1'b0, opnd_r}
                   - {8'h00, ~flg_r[`RSX_FLAG_C]};
    assign ldiff = {1'b0, acc_r[3:0]} - {1'b0, opnd_r[3:0]}
                   - {4'h0, ~flg_r[`RSX_FLAG_C]};
    assign rot   = {opnd_r[0], opnd_r[7:1]};

    always_comb begin
        flg_new = flg_r;
        if (is_rrnc) begin
            flg_new[`RSX_FLAG_N] = rot[7];
            flg_new[`RSX_FLAG_Z] = (rot == `RSX_ZERO8);
        end else if (is_subb) begin
            flg_new[`RSX_FLAG_N]  = diff[7];
            flg_new[`RSX_FLAG_Z]  = (diff[7:0] == `RSX_ZERO8);
            flg_new[`RSX_FLAG_C]  = ~diff[8];
            flg_new[`RSX_FLAG_DIG] = ~ldiff[4];
            flg_new[`RSX_FLAG_OVF] = (acc_r[7] ^ opnd_r[7])
                                    & (acc_r[7] ^ diff[7]);
        end
    end

    // ----------------------------------------
    // phase sequencer
    // ----------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        busy_nxt  = busy_r;
        ir_nxt    = ir_r;
        addr_nxt  = addr_r;
        opnd_nxt  = opnd_r;
        res_nxt   = res_r;
        flg_nxt   = flg_r;
        acc_nxt   = acc_r;
        to_nxt    = to_r;
        pwrdn_nxt = pwrdn_r;
        sleep_nxt = sleep_r;
        wdclr_nxt = 1'b0;
        we_nxt    = 1'b0;
        wd_nxt    = wd_r;
        if (sleep_r) begin
            // only a watchdog wake leaves sleep here; other wake sources are outside
            if (watchdog_wake_in) begin
                sleep_nxt = 1'b0;
                to_nxt    = 1'b0;
            end
        end else begin
            case (phase_r)
                RSX_Q1: begin
                    if (instr_valid_in) begin
                        ir_nxt    = instr_in;
                        busy_nxt  = 1'b1;
                        phase_nxt = RSX_Q2;
                    end
                end
                RSX_Q2: begin
                    addr_nxt  = ai.addr;
                    opnd_nxt  = mem_rdata_in;
                    phase_nxt = RSX_Q3;
                end
                RSX_Q3: begin
                    if (is_rrnc) begin
                        res_nxt = rot;
                    end else if (is_subb) begin
                        res_nxt = diff[7:0];
                    end else begin
                        res_nxt = `RSX_ALL_ONES;
                    end
                    flg_nxt   = flg_new;
                    phase_nxt = RSX_Q4;
                end
                RSX_Q4: begin
                    if (is_setall) begin
                        we_nxt = 1'b1;
                        wd_nxt = res_r;
                    end else if (is_rrnc || is_subb) begin
                        if (ir_r[`RSX_BIT_D]) begin
                            we_nxt = 1'b1;
                            wd_nxt = res_r;
                        end else begin
                            acc_nxt = res_r;
                        end
                    end else if (is_sleep) begin
                        pwrdn_nxt = 1'b0;
                        to_nxt    = 1'b1;
                        wdclr_nxt = 1'b1;
                        sleep_nxt = 1'b1;
                    end
                    busy_nxt  = 1'b0;
                    phase_nxt = RSX_Q1;
                end
                default: begin
                    phase_nxt = RSX_Q1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            phase_r <= RSX_Q1;
            busy_r  <= 1'b0;
            ir_r    <= 16'h0000;
            addr_r  <= 12'h000;
            opnd_r  <= 8'h00;
            res_r   <= 8'h00;
            flg_r   <= 5'h00;
            acc_r   <= 8'h00;
            to_r    <= 1'b1;
            pwrdn_r <= 1'b1;
            sleep_r <= 1'b0;
            wdclr_r <= 1'b0;
            we_r    <= 1'b0;
            wd_r    <= 8'h00;
        end else begin
            phase_r <= phase_nxt;
            busy_r  <= busy_nxt;
            ir_r    <= ir_nxt;
            addr_r  <= addr_nxt;
            opnd_r  <= opnd_nxt;
            res_r   <= res_nxt;
            flg_r   <= flg_nxt;
            acc_r   <= acc_nxt;
            to_r    <= to_nxt;
            pwrdn_r <= pwrdn_nxt;
            sleep_r <= sleep_nxt;
            wdclr_r <= wdclr_nxt;
            we_r    <= we_nxt;
            wd_r    <= wd_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // address is combinational in phase two so the read returns in time
    assign mem_addr_out              = (phase_r == RSX_Q2) ? ai.addr : addr_r;
    assign mem_we_out                = we_r;
    assign mem_wdata_out             = wd_r;
    assign acc_out                   = acc_r;
    assign status_out                = flg_r;
    assign timeout_status_bit_out    = to_r;
    assign power_down_status_bit_out = pwrdn_r;
    assign watchdog_clear_out        = wdclr_r;
    assign sleeping_out              = sleep_r;
    assign phase_out                 = phase_r;
    assign busy_out                  = busy_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_rrnc_rotate: assert property (
        (phase_r == RSX_Q3) && is_rrnc |=> res_r == {$past(opnd_r[0]), $past(opnd_r[7:1])})
        else $error("rotate result wrong");
    a_rrnc_flags: assert property (
        (phase_r == RSX_Q3) && is_rrnc |=> flg_r[`RSX_FLAG_C] == $past(flg_r[`RSX_FLAG_C])
        && flg_r[`RSX_FLAG_Z] == (res_r == `RSX_ZERO8) && flg_r[`RSX_FLAG_N] == res_r[7])
        else $error("rotate flags wrong");
    a_dest_acc: assert property (
        (phase_r == RSX_Q4) && (is_rrnc || is_subb) && !ir_r[`RSX_BIT_D]
        |=> acc_r == $past(res_r) && !mem_we_out)
        else $error("accumulator destination wrong");
    a_dest_file: assert property (
        (phase_r == RSX_Q4) && (is_rrnc || is_subb) && ir_r[`RSX_BIT_D]
        |=> mem_we_out && mem_wdata_out == $past(res_r) && acc_r == $past(acc_r))
        else $error("file destination wrong");
    a_bank_sel: assert property (
        (phase_r == RSX_Q2) && ir_r[`RSX_BIT_A]
        |-> mem_addr_out == {bank_select_reg_in, ir_r[7:0]})
        else $error("banked address wrong");
    a_access_bank: assert property (
        (phase_r == RSX_Q2) && !ir_r[`RSX_BIT_A] && !ext_mode_in
        |-> mem_addr_out[7:0] == ir_r[7:0])
        else $error("access bank address wrong");
    a_ilo_mode: assert property (
        (phase_r == RSX_Q2) && !ir_r[`RSX_BIT_A] && ext_mode_in
        && ir_r[7:0] <= `RSX_ILO_LIMIT |-> mem_addr_out == index_base_in + {4'h0, ir_r[7:0]})
        else $error("indexed literal offset wrong");
    a_one_cycle: assert property (
        (phase_r == RSX_Q1) && instr_valid_in && !sleep_r
        |=> phase_r == RSX_Q2 ##1 phase_r == RSX_Q3 ##1 phase_r == RSX_Q4 ##1 phase_r == RSX_Q1)
        else $error("phase sequence wrong");
    a_set_all_ones: assert property (
        (phase_r == RSX_Q4) && is_setall |=> mem_we_out && mem_wdata_out == `RSX_ALL_ONES
        && flg_r == $past(flg_r))
        else $error("set file wrong");
    a_sleep_entry: assert property (
        (phase_r == RSX_Q4) && is_sleep |=> sleep_r && !pwrdn_r && to_r && wdclr_r)
        else $error("sleep entry wrong");
    a_watchdog_clear: assert property (
        wdclr_r |-> $past(phase_r) == RSX_Q4 && $past(is_sleep))
        else $error("watchdog clear without sleep");
    a_watchdog_wake: assert property (
        sleep_r && watchdog_wake_in |=> !sleep_r && !to_r)
        else $error("watchdog wake wrong");
    a_sub_result: assert property (
        (phase_r == RSX_Q3) && is_subb |=> res_r == $past(diff[7:0])
        && flg_r[`RSX_FLAG_C] == ~$past(diff[8]))
        else $error("subtract result wrong");
    a_sub_flags: assert property (
        (phase_r == RSX_Q3) && is_subb |=> flg_r[`RSX_FLAG_Z] == (res_r == `RSX_ZERO8)
        && flg_r[`RSX_FLAG_N] == res_r[7])
        else $error("subtract flags wrong");

    // ----------------------------------------
    // address former checks
    // ----------------------------------------
    a_access_low: assert property (
        (phase_r == RSX_Q2) && !ir_r[`RSX_BIT_A] && !ext_mode_in
        && (ir_r[7:0] < `RSX_ACCESS_SPLIT) |-> mem_addr_out == {4'h0, ir_r[7:0]})
        else $error("low access bank address wrong");
    // upper access half sits above the offset window, extended mode or not
    a_access_high: assert property (
        (phase_r == RSX_Q2) && !ir_r[`RSX_BIT_A] && (ir_r[7:0] >= `RSX_ACCESS_SPLIT)
        |-> mem_addr_out == {`RSX_HIGH_BANK, ir_r[7:0]})
        else $error("high access bank address wrong");

    // ----------------------------------------
    // subtract flag checks
    // ----------------------------------------
    // carry and digit carry rebuilt by comparison, not from the adder, so a shared slip shows
    a_sub_carry: assert property (
        (phase_r == RSX_Q3) && is_subb |=> flg_r[`RSX_FLAG_C] == ({1'b0, $past(acc_r)}
        >= ({1'b0, $past(opnd_r)} + {8'h00, ~$past(flg_r[`RSX_FLAG_C])})))
        else $error("subtract carry wrong");
    a_sub_digit: assert property (
        (phase_r == RSX_Q3) && is_subb |=> flg_r[`RSX_FLAG_DIG] == ({1'b0, $past(acc_r[3:0])}
        >= ({1'b0, $past(opnd_r[3:0])} + {4'h0, ~$past(flg_r[`RSX_FLAG_C])})))
        else $error("subtract digit carry wrong");
    a_sub_ovf: assert property (
        (phase_r == RSX_Q3) && is_subb |=> flg_r[`RSX_FLAG_OVF]
        == (($past(acc_r[7]) != $past(opnd_r[7])) && (res_r[7] != $past(acc_r[7]))))
        else $error("subtract overflow wrong");

    // ----------------------------------------
    // sequencing and sleep checks
    // ----------------------------------------
    a_busy_phase: assert property (
        busy_r == (phase_r != RSX_Q1))
        else $error("busy flag out of step with phase");
    a_write_pulse: assert property (
        mem_we_out |=> !mem_we_out)
        else $error("write strobe longer than one cycle");
    a_set_flags_hold: assert property (
        (phase_r == RSX_Q3) && is_setall |=> flg_r == $past(flg_r))
        else $error("set file touched the flags");
    a_sleep_halt: assert property (
        sleep_r && !watchdog_wake_in |=> sleep_r && (phase_r == RSX_Q1) && !busy_r)
        else $error("core ran while asleep");
    a_sleep_no_write: assert property (
        (phase_r == RSX_Q4) && is_sleep |=> !mem_we_out && acc_r == $past(acc_r))
        else $error("sleep changed memory or accumulator");
    a_timeout_hold: assert property (
        !sleep_r && !((phase_r == RSX_Q4) && is_sleep) |=> to_r == $past(to_r))
        else $error("timeout bit moved while awake");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_rrnc: cover property ((phase_r == RSX_Q4) && is_rrnc);
    c_set_all: cover property ((phase_r == RSX_Q4) && is_setall);
    c_sleep_wake: cover property (sleep_r && watchdog_wake_in);
    c_sub_borrow: cover property ((phase_r == RSX_Q3) && is_subb && diff[8]);
    c_ilo_mode: cover property ((phase_r == RSX_Q2) && !ir_r[`RSX_BIT_A] && ext_mode_in
        && (ir_r[7:0] <= `RSX_ILO_LIMIT));
endmodule

/* File: hdl/rsx_defines.svh */
// constants for the rotate/set/sleep/subtract execute block
// Summary of operation
// - rotate right: bit 0 wraps to bit 7
// - rotate right updates only negative and zero
// - dest bit 0 to accumulator, 1 to file
// - bank bit 0 selects access bank
// - bank bit 1 uses bank select register
// - extended mode, f<=95: indexed literal offset
// - set file writes all ones, flags untouched
// - fixed sleep pattern halts in phase one
// - sleep clears power-down status bit
// - sleep sets timeout status bit
// - sleep clears watchdog counter and postscaler
// - watchdog wake-up clears timeout status bit
// - subtract: acc minus file minus inverted carry
// - subtract updates all five arithmetic flags
// - subtract result goes to selected destination
`ifndef RSX_DEFINES_SVH
`define RSX_DEFINES_SVH
`define RSX_OP6_RRNC      6'h10
`define RSX_OP6_SUBB      6'h15
`define RSX_OP7_SET1      7'h34
`define RSX_SLEEP_WORD    16'h0003
`define RSX_ILO_LIMIT     8'h5F
`define RSX_ACCESS_SPLIT  8'h60
`define RSX_HIGH_BANK     4'hF
`define RSX_ALL_ONES      8'hFF
`define RSX_ZERO8         8'h00
`define RSX_BIT_D         9
`define RSX_BIT_A         8
`define RSX_FLAG_C        0
`define RSX_FLAG_DIG      1
`define RSX_FLAG_Z        2
`define RSX_FLAG_OVF      3
`define RSX_FLAG_N        4
`endif

/* File: hdl/rsx_pkg.sv */
// types for the rotate/set/sleep/subtract execute block
package rsx_pkg;
    typedef enum logic [3:0] {
        RSX_Q1 = 4'b0001,
        RSX_Q2 = 4'b0010,
        RSX_Q3 = 4'b0100,
        RSX_Q4 = 4'b1000
    } rsx_phase_e;
    typedef logic [11:0] rsx_addr_t;
endpackage

/* File: hdl/rsx_addr_if.sv */
// address request carrier between execute core and address former
`timescale 1ns/1ps
interface rsx_addr_if;
    logic              bank_sel;
    logic              ext_mode;
    logic [7:0]        file_lit;
    logic [3:0]        bank_reg;
    logic [11:0]       index_base;
    rsx_pkg::rsx_addr_t addr;
    modport core (output bank_sel, ext_mode, file_lit, bank_reg, index_base, input addr);
    modport former (input bank_sel, ext_mode, file_lit, bank_reg, index_base, output addr);
endinterface

/* File: hdl/rsx_addr_former.sv */
// data memory address former: access bank, banked, indexed literal offset
`timescale 1ns/1ps
`include "rsx_defines.svh"
module rsx_addr_former (
    rsx_addr_if.former ai
);
    import rsx_pkg::*;
    always_comb begin
        if (ai.bank_sel) begin
            ai.addr = {ai.bank_reg, ai.file_lit};
        end else if (ai.ext_mode && (ai.file_lit <= `RSX_ILO_LIMIT)) begin
            ai.addr = ai.index_base + {4'h0, ai.file_lit};
        end else if (ai.file_lit < `RSX_ACCESS_SPLIT) begin
            ai.addr = {4'h0, ai.file_lit};
        end else begin
            ai.addr = {`RSX_HIGH_BANK, ai.file_lit};
        end
    end
endmodule

/* File: tb/tb_cpu_rotate_set_sleep_subtract_exec.sv */
// self-checking bench for the rotate/set/sleep/subtract execute core
`timescale 1ns/1ps
module tb_cpu_rotate_set_sleep_subtract_exec;
    import rsx_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        core_clk_in;
    logic        rst_in;
    logic        instr_valid_in;
    logic [15:0] instr_in;
    logic        ext_mode_in;
    logic [3:0]  bank_select_reg_in;
    logic [11:0] index_base_in;
    logic        watchdog_wake_in;
    logic [11:0] mem_addr_out;
    logic [7:0]  mem_rdata_in;
    logic        mem_we_out;
    logic [7:0]  mem_wdata_out;
    logic [7:0]  acc_out;
    logic [4:0]  status_out;
    logic        timeout_status_bit_out;
    logic        power_down_status_bit_out;
    logic        watchdog_clear_out;
    logic        sleeping_out;
    rsx_phase_e  phase_out;
    logic        busy_out;
    logic [7:0]  mem [0:4095];
    logic [7:0]  m_acc;
    logic [4:0]  m_st;
    int          mismatches;
    int          checked;
    // bank bits folded in so a wrong bank reads a different byte
    assign mem_rdata_in = mem[mem_addr_out];
    rsx_exec rsx_exec_inst (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .ext_mode_in(ext_mode_in),
        .bank_select_reg_in(bank_select_reg_in), .index_base_in(index_base_in),
        .watchdog_wake_in(watchdog_wake_in), .mem_addr_out(mem_addr_out),
        .mem_rdata_in(mem_rdata_in),
        .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
        .status_out(status_out), .timeout_status_bit_out(timeout_status_bit_out),
        .power_down_status_bit_out(power_down_status_bit_out),
        .watchdog_clear_out(watchdog_clear_out), .sleeping_out(sleeping_out),
        .phase_out(phase_out), .busy_out(busy_out)
    );
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // one instruction, checked phase by phase
    // ----------------------------------------
    task automatic exec_op(input logic [15:0] w, input logic ext, input logic [3:0] bank);
        logic [11:0] ea;
        logic [7:0]  fv;
        logic [7:0]  r;
        logic [8:0]  d9;
        logic [4:0]  dn;
        logic [4:0]  st;
        logic        rot;
        logic        sub;
        logic        sall;
        logic        slp;
        logic        p;
        int          n;
        rot = (w[15:10] == 6'h10);
        sub = (w[15:10] == 6'h15);
        sall = (w[15:9] == 7'h34);
        slp = (w == 16'h0003);
        if (w[8]) ea = {bank, w[7:0]};
        else if (ext && w[7:0] <= 8'h5F) ea = index_base_in + {4'h0, w[7:0]};
        else if (w[7:0] < 8'h60) ea = {4'h0, w[7:0]};
        else ea = {4'hF, w[7:0]};
        fv = mem[ea];
        st = m_st;
        r = m_acc;
        if (rot) begin
            r = {fv[0], fv[7:1]};
            st[4] = r[7];
            st[2] = (r == 8'h00);
        end
        if (sub) begin
            d9 = {1'b0, m_acc} - {1'b0, fv} - {8'h00, ~m_st[0]};
            dn = {1'b0, m_acc[3:0]} - {1'b0, fv[3:0]} - {4'h0, ~m_st[0]};
            r = d9[7:0];
            st = {r[7], (m_acc[7] != fv[7]) && (r[7] != m_acc[7]), r == 8'h00, ~dn[4], ~d9[8]};
        end
        if (sall) r = 8'hFF;
        @(posedge core_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= w;
        ext_mode_in <= ext;
        bank_select_reg_in <= bank;
        #1;
        n = 0;
        // taken only on the edge that closes a first-phase cycle
        do begin
            p = (phase_out === RSX_Q1);
            @(posedge core_clk_in);
            #1;
            n++;
        end while (!p && n < 8);
        if (!p) begin
            mismatches++;
            test_done();
        end
        check(phase_out, RSX_Q2);
        check(busy_out, 1'b1);
        if (!slp) check(mem_addr_out, ea);
        @(posedge core_clk_in);
        instr_valid_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        check(status_out, st);
        @(posedge core_clk_in);
        #1;
        check(busy_out, 1'b0);
        if ((rot || sub) && !w[9]) begin
            check(mem_we_out, 1'b0);
            check(acc_out, r);
            m_acc = r;
        end else if (rot || sub || sall) begin
            check(mem_we_out, 1'b1);
            check(mem_wdata_out, r);
            check(mem_addr_out, ea);
            check(acc_out, m_acc);
        end else begin
            check(sleeping_out, 1'b1);
            check(power_down_status_bit_out, 1'b0);
            check(timeout_status_bit_out, 1'b1);
            check(watchdog_clear_out, 1'b1);
            check(acc_out, m_acc);
        end
        m_st = st;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_subtract;
        @(posedge core_clk_in);
        index_base_in <= 12'h320;
        exec_op(16'h5410, 1'b0, 4'h0);
        exec_op(16'h5710, 1'b0, 4'h2);
        exec_op(16'h5455, 1'b1, 4'h0);
        exec_op(16'h5460, 1'b1, 4'h0);
        exec_op(16'h55A4, 1'b0, 4'h0);
        exec_op(16'h5527, 1'b1, 4'h0);
        exec_op(16'h54C3, 1'b0, 4'h0);
        $display("subtract test done");
    endtask
    task automatic t_rotate;
        exec_op(16'h4010, 1'b0, 4'h0);
        exec_op(16'h4210, 1'b0, 4'h0);
        exec_op(16'h4160, 1'b1, 4'h5);
        exec_op(16'h405F, 1'b1, 4'h0);
        exec_op(16'h40F0, 1'b1, 4'h0);
        $display("rotate test done");
    endtask
    task automatic t_set_all;
        exec_op(16'h6810, 1'b0, 4'h0);
        exec_op(16'h6905, 1'b1, 4'h7);
        exec_op(16'h685F, 1'b1, 4'h0);
        $display("set test done");
    endtask
    task automatic t_sleep;
        int n;
        exec_op(16'h0003, 1'b0, 4'h0);
        @(posedge core_clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= 16'h4010;
        #1;
        check(watchdog_clear_out, 1'b0);
        // asleep: a valid word must not start anything
        repeat (8) begin
            @(posedge core_clk_in);
            #1;
            check(busy_out, 1'b0);
        end
        @(posedge core_clk_in);
        instr_valid_in <= 1'b0;
        watchdog_wake_in <= 1'b1;
        @(posedge core_clk_in);
        watchdog_wake_in <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            n++;
        end while (sleeping_out !== 1'b0 && n < 8);
        check(sleeping_out, 1'b0);
        check(timeout_status_bit_out, 1'b0);
        exec_op(16'h4210, 1'b0, 4'h0);
        $display("sleep test done");
    endtask
    // ----------------------------------------
    // clock and main sequence
    // ----------------------------------------
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial begin
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        instr_in = 16'h0000;
        ext_mode_in = 1'b0;
        bank_select_reg_in = 4'h0;
        index_base_in = 12'h000;
        watchdog_wake_in = 1'b0;
        mismatches = 0;
        checked = 0;
        m_acc = 8'h00;
        m_st = 5'h00;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ {i[11:8], i[11:8]} ^ 8'hA5;
        end
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1;
        check(timeout_status_bit_out, 1'b1);
        check(power_down_status_bit_out, 1'b1);
        check(phase_out, RSX_Q1);
        check(status_out, 5'h00);
        check(acc_out, 8'h00);
        $display("reset test done");
        t_subtract();
        t_rotate();
        t_set_all();
        t_sleep();
        test_done();
    end
endmodule
